// ---- hdl/rscc_pkg.sv ----
// Package for the reset-time strap capture block.
// Assumes a single 25 MHz clock domain.
package rscc_pkg;
    // Frame size limits in bytes
    localparam logic [10:0] RSCC_MAX_TAGGED = 11'd1522;
    localparam logic [10:0] RSCC_MAX_UNTAGGED = 11'd1518;
    localparam logic [10:0] RSCC_MAX_LONG = 11'd1536;
    // Serial configuration select encodings
    typedef enum logic [1:0] {
        RSCC_SER_I2C_MASTER = 2'b00,
        RSCC_SER_RESERVED = 2'b01,
        RSCC_SER_SPI_SLAVE = 2'b10,
        RSCC_SER_SELF_TEST = 2'b11
    } rscc_ser_mode_t;
    // Reset values
    localparam logic RSCC_RST_RX_ERR_STRAP = 1'b0;
    localparam logic [1:0] RSCC_RST_SER_SEL = 2'b00;
    // Reset release sync stages
    localparam int RSCC_SYNC_STAGES = 2;
    typedef enum logic [1:0] {
        RSCC_ST_RESET = 2'b00,
        RSCC_ST_CAPTURE = 2'b01,
        RSCC_ST_RUN = 2'b10
    } rscc_state_t;
endpackage

// ---- hdl/rscc_strap_capture.sv ----
// Reset-time strap capture and chip reset / power-down control.
// Assumes strap and pin inputs synchronous to i_clock; board supplies pulls.
`timescale 1ns/1ps
module rscc_strap_capture (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // Board-level control
    input wire logic i_full_chip_sleep_low,
    input wire logic i_eeprom_present,
    // Strap pin inputs
    input wire logic i_phy5_rx_error_strap,
    input wire logic i_phy5_rx_valid_pin,
    input wire logic i_serial_cfg_sel_bit0,
    input wire logic i_serial_cfg_sel_bit1,
    // Functional values for dual-purpose pins after reset
    input wire logic i_phy5_rx_error_func,
    input wire logic i_phy5_rx_valid_func,
    // Dual-purpose pin drive
    output logic o_phy5_rx_error_out,
    output logic o_phy5_rx_error_oe,
    output logic o_phy5_rx_valid_out,
    output logic o_phy5_rx_valid_oe,
    // Chip control and captured configuration
    output logic o_core_reset_n,
    output logic o_sleep,
    output logic o_long_frames,
    output logic [10:0] o_max_tagged_len,
    output logic [10:0] o_max_untagged_len,
    output rscc_pkg::rscc_ser_mode_t o_serial_mode,
    output logic o_i2c_master_en,
    output logic o_spi_slave_en,
    output logic o_self_test_en,
    output logic o_cfg_valid
);
    import rscc_pkg::*;

    // Release timing, in rising edges after i_reset_n goes high:
    // edges 1 and 2 fill the release shifter, edge 3 enters CAPTURE,
    // edge 4 samples the straps and enters RUN, edge 5 frees the core.
    // The shifter keeps a release that lands near an edge from
    // capturing straps that the board is still settling.
    // Limitation: i_phy5_rx_valid_pin has no strap meaning and is
    // only observed by the board, never latched here.

    typedef struct packed {
        // Release shifter and sequence state
        logic [RSCC_SYNC_STAGES-1:0] rel;
        rscc_state_t st;
        // Latched strap levels
        logic rx_err_strap;
        logic [1:0] ser_sel;
        // Dual-purpose pin drive
        logic err_out;
        logic err_oe;
        logic val_out;
        logic val_oe;
        // Chip control and decoded configuration
        logic core_rst_n;
        logic sleep;
        logic long_fr;
        logic [10:0] max_tag;
        logic [10:0] max_untag;
        rscc_ser_mode_t mode;
        logic i2c_en;
        logic spi_en;
        logic factory_self_test_mode_en;
        logic valid;
    } rscc_regs_t;

    rscc_regs_t state_q;
    rscc_regs_t state_d;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_d = state_q;
        // Release shift; reset itself is async, release is clocked
        state_d.rel = {state_q.rel[RSCC_SYNC_STAGES-2:0], 1'b1};

        // Sleep and core reset are plain levels with one cycle of lag
        if (!i_full_chip_sleep_low) begin
            state_d.sleep = 1'b1;
            state_d.core_rst_n = 1'b0;
        end else begin
            state_d.sleep = 1'b0;
            // Core held in reset until straps are captured
            state_d.core_rst_n = (state_q.st == RSCC_ST_RUN);
        end

        ////////////////////////////////////////////////////////////////////
        unique case (state_q.st)
            // Wait for the release to pass the shifter
            RSCC_ST_RESET: begin
                if (state_q.rel[RSCC_SYNC_STAGES-1]) begin
                    state_d.st = RSCC_ST_CAPTURE;
                end
            end
            RSCC_ST_CAPTURE: begin
                // Sample once after release; no later edge reloads these
                state_d.rx_err_strap = i_phy5_rx_error_strap;
                state_d.ser_sel = i_eeprom_present
                    ? {i_serial_cfg_sel_bit1, i_serial_cfg_sel_bit0}
                    : RSCC_RST_SER_SEL;
                state_d.st = RSCC_ST_RUN;
            end
            // Straps stay frozen until the next reset
            RSCC_ST_RUN: begin
                state_d.st = RSCC_ST_RUN;
            end
            // Unused code falls back to RESET; the already full shifter sends it on to CAPTURE
            default: begin
                state_d.st = RSCC_ST_RESET;
            end
        endcase

        ////////////////////////////////////////////////////////////////////
        // Frame size limits follow the latched strap, never the live pin
        if (state_d.rx_err_strap) begin
            state_d.long_fr = 1'b1;
            state_d.max_tag = RSCC_MAX_LONG;
            state_d.max_untag = RSCC_MAX_LONG;
        end else begin
            state_d.long_fr = 1'b0;
            state_d.max_tag = RSCC_MAX_TAGGED;
            state_d.max_untag = RSCC_MAX_UNTAGGED;
        end

        // Serial interface decode; the reserved code enables nothing
        state_d.mode = rscc_ser_mode_t'(state_d.ser_sel);
        state_d.i2c_en = 1'b0;
        state_d.spi_en = 1'b0;
        state_d.factory_self_test_mode_en = 1'b0;
        unique case (state_d.mode)
            RSCC_SER_I2C_MASTER: begin
                state_d.i2c_en = 1'b1;
            end
            RSCC_SER_RESERVED: begin
                // No interface claims the serial pins
                state_d.i2c_en = 1'b0;
            end
            RSCC_SER_SPI_SLAVE: begin
                state_d.spi_en = 1'b1;
            end
            RSCC_SER_SELF_TEST: begin
                state_d.factory_self_test_mode_en = 1'b1;
            end
        endcase

        // Configuration counts as valid only in RUN
        state_d.valid = (state_d.st == RSCC_ST_RUN);

        // Pins drive only once configuration is latched; pulls act before
        if (state_d.st == RSCC_ST_RUN) begin
            state_d.err_oe = 1'b1;
            state_d.val_oe = 1'b1;
            state_d.err_out = i_phy5_rx_error_func;
            state_d.val_out = i_phy5_rx_valid_func;
        end else begin
            // Released pins show low so nothing fights the pulls
            state_d.err_oe = 1'b0;
            state_d.val_oe = 1'b0;
            state_d.err_out = 1'b0;
            state_d.val_out = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            // Outputs released and core held; lengths show the default
            state_q <= '0;
            state_q.st <= RSCC_ST_RESET;
            state_q.rx_err_strap <= RSCC_RST_RX_ERR_STRAP;
            state_q.ser_sel <= RSCC_RST_SER_SEL;
            state_q.max_tag <= RSCC_MAX_TAGGED;
            state_q.max_untag <= RSCC_MAX_UNTAGGED;
            state_q.mode <= RSCC_SER_I2C_MASTER;
            state_q.i2c_en <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drive
    assign o_phy5_rx_error_out = state_q.err_out;
    assign o_phy5_rx_error_oe = state_q.err_oe;
    assign o_phy5_rx_valid_out = state_q.val_out;
    assign o_phy5_rx_valid_oe = state_q.val_oe;

    // Chip control
    assign o_core_reset_n = state_q.core_rst_n;
    assign o_sleep = state_q.sleep;

    // Captured configuration
    assign o_long_frames = state_q.long_fr;
    assign o_max_tagged_len = state_q.max_tag;
    assign o_max_untagged_len = state_q.max_untag;
    assign o_serial_mode = state_q.mode;
    assign o_i2c_master_en = state_q.i2c_en;
    assign o_spi_slave_en = state_q.spi_en;
    assign o_self_test_en = state_q.factory_self_test_mode_en;
    assign o_cfg_valid = state_q.valid;
endmodule

// ---- tb/rscc_board.sv ----
// Board strap model; an undriven pin falls to its resistor.
`timescale 1ns/1ps
module rscc_board (input wire logic i_pull, i_oe, i_out, output logic o_pin);
    assign o_pin = i_oe ? i_out : i_pull;
endmodule

// ---- tb/rscc_strap_capture_asserts.sv ----
// Port checker bound into the strap capture block; one clock domain.
`timescale 1ns/1ps
module rscc_strap_capture_asserts import rscc_pkg::*; (
    input wire logic i_clock, i_reset_n, i_full_chip_sleep_low, i_eeprom_present, i_phy5_rx_error_strap,
    input wire logic i_serial_cfg_sel_bit0, i_serial_cfg_sel_bit1, o_phy5_rx_error_oe, o_core_reset_n,
    input wire logic o_sleep, o_long_frames, o_cfg_valid,
    input wire rscc_ser_mode_t o_serial_mode
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    sequence s_cap; $rose(o_cfg_valid); endsequence
    sequence s_run; o_cfg_valid ##1 o_cfg_valid; endsequence
    AST_OE: assert property (o_cfg_valid == o_phy5_rx_error_oe) else $error("drive");
    AST_FRAME: assert property (s_cap |-> o_long_frames == $past(i_phy5_rx_error_strap)) else $error("frame");
    AST_MODE: assert property (s_cap |-> o_serial_mode == ($past(i_eeprom_present) ?
        {$past(i_serial_cfg_sel_bit1), $past(i_serial_cfg_sel_bit0)} : 2'h0)) else $error("mode");
    AST_HOLD: assert property (s_run |-> $stable(o_long_frames) && $stable(o_serial_mode)) else $error("hold");
    AST_SLEEP: assert property (!i_full_chip_sleep_low |=> o_sleep && !o_core_reset_n) else $error("sleep");
    AST_WAKE: assert property (i_full_chip_sleep_low |=> !o_sleep) else $error("wake");
    AST_CORE: assert property ($rose(o_core_reset_n) |-> $past(o_cfg_valid)) else $error("core");
endmodule
bind rscc_strap_capture rscc_strap_capture_asserts u_chk (.*);

// ---- tb/testbench.sv ----
// Bench: reset cycles over strap settings; board model resolves the pin.
`timescale 1ns/1ps
module testbench;
    import rscc_pkg::*;
    logic i_clock = 0, i_reset_n = 0, i_full_chip_sleep_low = 1, i_eeprom_present = 1, pull = 0;
    logic i_serial_cfg_sel_bit0 = 0, i_serial_cfg_sel_bit1 = 0, i_phy5_rx_error_func = 0, i_phy5_rx_valid_func = 0;
    logic i_phy5_rx_error_strap, i_phy5_rx_valid_pin, o_phy5_rx_error_out, o_phy5_rx_error_oe;
    logic o_phy5_rx_valid_out, o_phy5_rx_valid_oe, o_core_reset_n, o_sleep, o_long_frames, o_cfg_valid;
    logic o_i2c_master_en, o_spi_slave_en, o_self_test_en;
    logic [10:0] o_max_tagged_len, o_max_untagged_len;
    rscc_ser_mode_t o_serial_mode;
    logic [1:0] m;
    logic [27:0] exp_q[$], cur;
    int failures = 0, total_checks = 0, seed = 39;
    wire [27:0] cfg = {o_long_frames, o_serial_mode, o_max_tagged_len, o_max_untagged_len,
        o_i2c_master_en, o_spi_slave_en, o_self_test_en};
    rscc_strap_capture i_rscc_strap_capture (.*);
    rscc_board i_rscc_board (.i_pull(pull), .i_oe(o_phy5_rx_error_oe), .i_out(o_phy5_rx_error_out),
        .o_pin(i_phy5_rx_error_strap));
    rscc_board i_rscc_board_valid (.i_pull(1'b0), .i_oe(o_phy5_rx_valid_oe), .i_out(o_phy5_rx_valid_out),
        .o_pin(i_phy5_rx_valid_pin));
    task automatic check(string n, logic [27:0] e, v);
        total_checks++;
        failures += (e !== v);
        if (e !== v) $display("Error %s expected %h seen %h", n, e, v);
    endtask
    task automatic end_of_test;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial forever #20 i_clock = ~i_clock;
    always @(posedge o_cfg_valid) @(negedge i_clock) check("config", exp_q.pop_front(), cfg);
    initial begin
        #20000 failures++;
        end_of_test();
    end
    initial begin
        repeat (10) @(negedge i_clock);
        for (int i = 0; i < 8; i++) begin
            {pull, i_eeprom_present} = 2'($random(seed));
            i_eeprom_present |= i < 4;
            {i_serial_cfg_sel_bit1, i_serial_cfg_sel_bit0} = i[1:0];
            m = i_eeprom_present ? i[1:0] : 2'h0;
            cur = {pull, m, pull ? RSCC_MAX_LONG : RSCC_MAX_TAGGED,
                pull ? RSCC_MAX_LONG : RSCC_MAX_UNTAGGED, m == 0, m == 2, m == 3};
            exp_q.push_back(cur);
            @(negedge i_clock);
            check("reset pins", {pull, 4'h0}, {i_phy5_rx_error_strap, i_phy5_rx_valid_pin, o_phy5_rx_error_oe,
                o_phy5_rx_valid_oe, o_core_reset_n});
            i_reset_n = 1;
            repeat (5) @(negedge i_clock);
            // Straps move after capture; outputs must not
            {i_serial_cfg_sel_bit1, i_serial_cfg_sel_bit0, pull} = ~{i[1:0], pull};
            {i_eeprom_present, i_phy5_rx_error_func, i_phy5_rx_valid_func} = 3'($random(seed));
            repeat (2) @(negedge i_clock);
            check("held", cur, cfg);
            check("run pins", {i_phy5_rx_error_func, i_phy5_rx_valid_func, 3'h7}, {i_phy5_rx_error_strap,
                i_phy5_rx_valid_pin, o_phy5_rx_error_oe, o_phy5_rx_valid_oe, o_core_reset_n});
            i_full_chip_sleep_low = 0;
            repeat (2) @(negedge i_clock);
            check("sleep", 2'h2, {o_sleep, o_core_reset_n});
            i_full_chip_sleep_low = 1;
            i_reset_n = 0;
        end
        end_of_test();
    end
endmodule
